// *** logic/sps_regs.sv ***
// Status, prescale and interrupt register bank of a synchronous serial port.
// Assumes queue levels and shifter events come from the port's datapath
// in the same clock domain; software uses classic Wishbone single cycles.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/10ps
module sps_regs
	import sps_pkg::*;
(
	input  wire logic             clk_i,           // 200 MHz system clock
	input  wire logic             rst_i,           // sync reset, active high
	input  wire logic             wb_cyc_i,        // bus cycle
	input  wire logic             wb_stb_i,        // bus strobe
	input  wire logic             wb_we_i,         // write enable
	input  wire logic [ADR_W-1:0] wb_adr_i,        // byte address
	input  wire logic [3:0]       wb_sel_i,        // byte lanes
	input  wire logic [DAT_W-1:0] wb_dat_i,        // write data
	output logic      [DAT_W-1:0] wb_dat_o,        // read data
	output logic                  wb_ack_o,        // acknowledge
	input  wire logic [LVL_W-1:0] tx_level_i,      // transmit queue entries
	input  wire logic [LVL_W-1:0] rx_level_i,      // receive queue entries
	input  wire logic             shifter_busy_i,  // frame in progress
	input  wire logic             rx_timeout_i,    // receive timeout pulse
	input  wire logic             rx_word_in_i,    // received word pulse
	output logic                  prescale_tick_o, // divided clock enable
	output logic                  irq_o,           // combined interrupt
	output logic                  evt_irq_o        // event interrupt
);
	import sps_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	logic                  req;
	logic                  wr_fire;
	logic                  rd_take;
	logic [ADR_W-1:0]      adr_word;

	assign req      = wb_cyc_i & wb_stb_i;
	assign adr_word = {wb_adr_i[ADR_W-1:2], 2'b00};
	// Writes land on the edge at which the master samples ack
	assign wr_fire  = req & wb_we_i & wb_ack_o & wb_sel_i[0];
	// Reads are captured as ack is raised
	assign rd_take  = req & ~wb_we_i & ~wb_ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Queue and busy status
	logic [4:0] status_reg;
	logic [4:0] status_next;

	always_comb begin
		status_next             = '0;
		status_next[ST_BUSY]    = shifter_busy_i | (tx_level_i != '0);
		status_next[ST_RXFULL]  = (rx_level_i == QUEUE_DEPTH);
		status_next[ST_RXDATA]  = (rx_level_i != '0);
		status_next[ST_TXROOM]  = (tx_level_i != QUEUE_DEPTH);
		status_next[ST_TXEMPTY] = (tx_level_i == '0);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_reg <= STATUS_RST;
		end else begin
			status_reg <= status_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Prescale divisor
	logic [PSC_W-1:0] prescale_reg;

	// Odd writes lose bit 0; software keeps the value even and >= 2
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prescale_reg <= PSC_RST;
		end else if (wr_fire && adr_word == OFF_PRESCL) begin
			prescale_reg <= {wb_dat_i[PSC_W-1:1], 1'b0};
		end
	end

	sps_prescale u_prescale (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.divisor_i (prescale_reg),
		.tick_o    (prescale_tick_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Interrupt mask
	logic [IRQ_W-1:0] mask_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_reg <= MASK_RST;
		end else if (wr_fire && adr_word == OFF_MASK) begin
			mask_reg <= wb_dat_i[IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Raw interrupt sources
	logic             overrun_evt;
	logic             clr_write;
	logic [1:0]       sticky_set;
	logic [1:0]       sticky_clr;
	logic [1:0]       sticky_q;
	logic             tx_lvl_reg;
	logic             rx_lvl_reg;
	logic [IRQ_W-1:0] raw_vec;
	logic [IRQ_W-1:0] masked_vec;

	// Overrun: a word arrives with no free receive entry
	assign overrun_evt = rx_word_in_i & (rx_level_i == QUEUE_DEPTH);
	assign clr_write   = wr_fire && adr_word == OFF_CLEAR;
	assign sticky_set  = {rx_timeout_i, overrun_evt};
	// Only the two held sources listen to the clear register
	assign sticky_clr  = clr_write ? wb_dat_i[1:0] : 2'b00;

	sps_sticky #(.W(2)) u_raw_sticky (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.set_i  (sticky_set),
		.clr_i  (sticky_clr),
		.flag_o (sticky_q)
	);

	// Level sources track the queues directly
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_lvl_reg <= RAW_RST[IR_TXLVL];
			rx_lvl_reg <= RAW_RST[IR_RXLVL];
		end else begin
			tx_lvl_reg <= (tx_level_i <= QUEUE_HALF);
			rx_lvl_reg <= (rx_level_i >= QUEUE_HALF);
		end
	end

	assign raw_vec    = {tx_lvl_reg, rx_lvl_reg, sticky_q};
	assign masked_vec = raw_vec & mask_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |masked_vec;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Event register: sticky, cleared by reading it
	logic [IRQ_W-1:0] evt_set;
	logic [IRQ_W-1:0] evt_clr;
	logic [IRQ_W-1:0] evt_q;
	logic [IRQ_W-1:0] evmask_reg;
	logic             tx_empty_d;
	logic             rx_full_d;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_empty_d <= 1'b1;
			rx_full_d  <= 1'b0;
		end else begin
			tx_empty_d <= status_next[ST_TXEMPTY];
			rx_full_d  <= status_next[ST_RXFULL];
		end
	end

	assign evt_set = {status_next[ST_TXEMPTY] & ~tx_empty_d,
	                  status_next[ST_RXFULL] & ~rx_full_d,
	                  rx_timeout_i, overrun_evt};
	assign evt_clr = (rd_take && adr_word == OFF_EVENT) ? evt_q : '0;

	sps_sticky #(.W(IRQ_W)) u_evt_sticky (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.set_i  (evt_set),
		.clr_i  (evt_clr),
		.flag_o (evt_q)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evmask_reg <= MASK_RST;
		end else if (wr_fire && adr_word == OFF_EVMASK) begin
			evmask_reg <= wb_dat_i[IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_irq_o <= 1'b0;
		end else begin
			evt_irq_o <= |(evt_q & evmask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data; writes to read-only and unmapped offsets are dropped
	logic [DAT_W-1:0] rd_next;

	always_comb begin
		rd_next = '0;
		unique case (adr_word)
			OFF_STATUS:  rd_next[4:0]       = status_reg;
			OFF_PRESCL:  rd_next[PSC_W-1:0] = prescale_reg;
			OFF_MASK:    rd_next[IRQ_W-1:0] = mask_reg;
			OFF_RAW:     rd_next[IRQ_W-1:0] = raw_vec;
			OFF_MASKED:  rd_next[IRQ_W-1:0] = masked_vec;
			OFF_EVENT:   rd_next[IRQ_W-1:0] = evt_q;
			OFF_EVMASK:  rd_next[IRQ_W-1:0] = evmask_reg;
			OFF_IDENT4:  rd_next[7:0]       = IDENT4_VAL;
			OFF_IDENT5:  rd_next[7:0]       = IDENT5_VAL;
			default:     rd_next            = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (rd_take) begin
			wb_dat_o <= rd_next;
		end else begin
			wb_dat_o <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence wr_mask_s;
		wr_fire && adr_word == OFF_MASK;
	endsequence

	sequence wr_clr_ovr_s;
		clr_write && wb_dat_i[0] && !overrun_evt;
	endsequence

	sequence read_ident4_s;
		rd_take && adr_word == OFF_IDENT4;
	endsequence

	chk_busy_flag: assert property (
		(shifter_busy_i || tx_level_i != '0) |=> status_reg[ST_BUSY])
		else $error("busy flag missed activity");

	chk_rx_full_flag: assert property (
		(rx_level_i != QUEUE_DEPTH) |=> !status_reg[ST_RXFULL])
		else $error("receive full flag set with free entry");

	chk_rx_data_flag: assert property (
		status_reg[ST_RXDATA] == ($past(rx_level_i) != '0))
		else $error("receive data flag wrong");

	chk_tx_room_empty: assert property (
		status_reg[ST_TXROOM] == ($past(tx_level_i) != QUEUE_DEPTH) &&
		status_reg[ST_TXEMPTY] == ($past(tx_level_i) == '0))
		else $error("transmit queue flags wrong");

	chk_prescale_even: assert property (
		wr_fire && adr_word == OFF_PRESCL |=>
		prescale_reg == {$past(wb_dat_i[PSC_W-1:1]), 1'b0})
		else $error("prescale write not stored even");

	chk_prescale_tick: assert property (
		prescale_tick_o && prescale_reg == 8'h02 && $stable(prescale_reg) &&
		!(wr_fire && adr_word == OFF_PRESCL)
		|=> !prescale_tick_o ##1 prescale_tick_o)
		else $error("divide by two enable spacing wrong");

	chk_mask_write: assert property (
		wr_mask_s |=> mask_reg == $past(wb_dat_i[IRQ_W-1:0]))
		else $error("mask write lost");

	chk_tx_level_raw: assert property (
		(tx_level_i > QUEUE_HALF) |=> !raw_vec[IR_TXLVL])
		else $error("transmit level raw set above half");

	chk_rx_level_raw: assert property (
		(rx_level_i >= QUEUE_HALF) |=> raw_vec[IR_RXLVL])
		else $error("receive level raw missed");

	chk_timeout_hold: assert property (
		rx_timeout_i ##1 !clr_write [*2] |-> raw_vec[IR_RXTO])
		else $error("timeout raw bit not held");

	chk_overrun_set: assert property (
		overrun_evt |=> raw_vec[IR_RXOVR])
		else $error("overrun raw bit not set");

	chk_overrun_clear: assert property (
		wr_clr_ovr_s |=> !raw_vec[IR_RXOVR])
		else $error("clear write did not clear overrun");

	chk_level_no_clear: assert property (
		clr_write && tx_level_i <= QUEUE_HALF && $stable(tx_level_i)
		|=> raw_vec[IR_TXLVL])
		else $error("clear register touched level source");

	chk_ident_read: assert property (
		read_ident4_s |=> wb_ack_o && wb_dat_o == {24'h00_0000, IDENT4_VAL})
		else $error("ident read wrong");

	chk_irq_or: assert property (
		irq_o == $past(|(raw_vec & mask_reg)))
		else $error("interrupt output not OR of masked bits");

	chk_bus_ack: assert property (
		req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one cycle after request");

	chk_data_idle: assert property (
		!wb_ack_o |-> wb_dat_o == '0)
		else $error("read data outside ack cycle");

	chk_mask_hold: assert property (
		!(wr_fire && adr_word == OFF_MASK) |=> $stable(mask_reg))
		else $error("mask changed without a write");

	chk_prescale_hold: assert property (
		!(wr_fire && adr_word == OFF_PRESCL) |=> $stable(prescale_reg))
		else $error("prescale changed without a write");

	chk_timeout_clear: assert property (
		clr_write && wb_dat_i[IR_RXTO] && !rx_timeout_i |=> !raw_vec[IR_RXTO])
		else $error("clear write did not clear timeout");

	chk_overrun_keep: assert property (
		clr_write && !wb_dat_i[IR_RXOVR] && raw_vec[IR_RXOVR]
		|=> raw_vec[IR_RXOVR])
		else $error("zero clear bit dropped overrun");

	chk_event_clear: assert property (
		rd_take && adr_word == OFF_EVENT && evt_set == '0 |=> evt_q == '0)
		else $error("event read did not clear");

	chk_event_irq: assert property (
		evt_irq_o == $past(|(evt_q & evmask_reg)))
		else $error("event interrupt not OR of masked events");

endmodule : sps_regs

// *** logic/sps_pkg.sv ***
// Constants of the serial port status and interrupt register bank.
// Assumes a single 200 MHz clock, synchronous reset and a Wishbone host.
//
// Operation
// - Busy while shifting or transmit queue holds data
// - Receive full flag at status bit 3
// - Receive has-data flag at status bit 2
// - Transmit has-room flag at bit 1, resets 1
// - Transmit drained flag at bit 0, resets 1
// - Divide clock by prescale, LSB always zero
// - Four read/write mask bits, cleared at reset
// - Transmit level raw at bit 3, resets 1
// - Receive level raw at bit 2 when half full
// - Timeout raw bit 1 sticky until cleared
// - Overrun raw bit 0 sticky until cleared
// - Raw status readable, writes ignored
// - Masked status readable, writes ignored
// - Clear register ones clear timeout and overrun
// - Read-only hard-coded identification bytes
package sps_pkg;

	////////////////////////////////////////////////////////////////////////
	// Bus geometry
	localparam int ADR_W = 12;
	localparam int DAT_W = 32;
	localparam int LVL_W = 4;
	localparam int IRQ_W = 4;
	localparam int PSC_W = 8;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [ADR_W-1:0] OFF_STATUS  = 12'h00c;
	localparam logic [ADR_W-1:0] OFF_PRESCL  = 12'h010;
	localparam logic [ADR_W-1:0] OFF_MASK    = 12'h014;
	localparam logic [ADR_W-1:0] OFF_RAW     = 12'h018;
	localparam logic [ADR_W-1:0] OFF_MASKED  = 12'h01c;
	localparam logic [ADR_W-1:0] OFF_CLEAR   = 12'h020;
	localparam logic [ADR_W-1:0] OFF_EVENT   = 12'h024;
	localparam logic [ADR_W-1:0] OFF_EVMASK  = 12'h028;
	localparam logic [ADR_W-1:0] OFF_IDENT4  = 12'hfd0;
	localparam logic [ADR_W-1:0] OFF_IDENT5  = 12'hfd4;

	////////////////////////////////////////////////////////////////////////
	// Status field positions
	localparam int ST_BUSY    = 4;
	localparam int ST_RXFULL  = 3;
	localparam int ST_RXDATA  = 2;
	localparam int ST_TXROOM  = 1;
	localparam int ST_TXEMPTY = 0;
	localparam logic [4:0] STATUS_RST = 5'h03;

	// Interrupt field positions of mask, raw, masked and clear; event shares bits 1 and 0 only
	localparam int IR_TXLVL = 3;
	localparam int IR_RXLVL = 2;
	localparam int IR_RXTO  = 1;
	localparam int IR_RXOVR = 0;
	localparam logic [IRQ_W-1:0] RAW_RST  = 4'h8;
	localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;
	localparam logic [PSC_W-1:0] PSC_RST  = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Queue geometry
	localparam logic [LVL_W-1:0] QUEUE_DEPTH = 4'h8;
	localparam logic [LVL_W-1:0] QUEUE_HALF  = 4'h4;

	// Identification bytes: values are arbitrary
	localparam logic [7:0] IDENT4_VAL = 8'h5a;
	localparam logic [7:0] IDENT5_VAL = 8'h3c;

endpackage : sps_pkg

// *** logic/sps_sticky.sv ***
// Sticky flag vector: set pulses hold until a clear pulse.
// Assumes set and clear are synchronous to clk_i.
`timescale 1ns/10ps
module sps_sticky #(
	parameter int W = 4
) (
	input  wire logic         clk_i,   // system clock
	input  wire logic         rst_i,   // sync reset, active high
	input  wire logic [W-1:0] set_i,   // set pulses
	input  wire logic [W-1:0] clr_i,   // clear pulses
	output logic      [W-1:0] flag_o   // held flags
);
	// Set beats a clear in the same cycle so no event is lost
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_o <= '0;
		end else begin
			flag_o <= (flag_o & ~clr_i) | set_i;
		end
	end
endmodule : sps_sticky

// *** logic/sps_prescale.sv ***
// Clock prescaler: one-cycle enable every divisor_i system clocks.
// Assumes divisor_i is even; zero stops the enable.
`timescale 1ns/10ps
module sps_prescale
	import sps_pkg::*;
(
	input  wire logic             clk_i,     // system clock
	input  wire logic             rst_i,     // sync reset, active high
	input  wire logic [PSC_W-1:0] divisor_i, // division factor
	output logic                  tick_o     // enable pulse
);
	logic [PSC_W-1:0] count_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i || divisor_i == '0) begin
			count_reg <= '0;
			tick_o    <= 1'b0;
		end else if (count_reg >= divisor_i - 8'h01) begin
			count_reg <= '0;
			tick_o    <= 1'b1;
		end else begin
			count_reg <= count_reg + 8'h01;
			tick_o    <= 1'b0;
		end
	end
endmodule : sps_prescale

// *** dv/sps_port_model.sv ***
// Far-side datapath stand-in: queue levels, shifter busy, receive events.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/10ps
module sps_port_model
	import sps_pkg::*;
(
	input  wire logic             clk_i,  // system clock
	output logic      [LVL_W-1:0] tx_o,   // transmit entries
	output logic      [LVL_W-1:0] rx_o,   // receive entries
	output logic                  busy_o, // frame shifting
	output logic                  to_o,   // timeout pulse
	output logic                  word_o  // word arrival pulse
);
	import sps_pkg::*;

	initial begin
		tx_o = '0;
		rx_o = '0;
		busy_o = 1'b0;
		to_o = 1'b0;
		word_o = 1'b0;
	end

	// Levels never exceed the queue depth
	task automatic set_lv(input logic [LVL_W-1:0] t, r, input logic b);
		tx_o <= (t > QUEUE_DEPTH) ? QUEUE_DEPTH : t;
		rx_o <= (r > QUEUE_DEPTH) ? QUEUE_DEPTH : r;
		busy_o <= b;
	endtask : set_lv

	// Events are single-cycle pulses
	task automatic pulse(input logic t, w);
		to_o <= t;
		word_o <= w;
		@(posedge clk_i);
		to_o <= 1'b0;
		word_o <= 1'b0;
	endtask : pulse

endmodule : sps_port_model

// *** dv/serial_port_status_irq_bench.sv ***
// Self-checking bench of the serial port status and interrupt bank.
// Assumes sps_regs answers single Wishbone cycles and a port model.
`timescale 1ns/10ps
module serial_port_status_irq_bench;
	import sps_pkg::*;

	logic             clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic             wb_cyc_i = 1'b0;
	logic             wb_stb_i = 1'b0;
	logic             wb_we_i = 1'b0;
	logic [ADR_W-1:0] wb_adr_i = '0;
	logic [3:0]       wb_sel_i = 4'h0;
	logic [DAT_W-1:0] wb_dat_i = '0;
	logic [DAT_W-1:0] wb_dat_o;
	logic             wb_ack_o, prescale_tick_o, irq_o, evt_irq_o;
	logic [LVL_W-1:0] tx_l, rx_l;
	logic             busy, to_p, word_p, ovr, w;
	logic [3:0]       t, r, mk, sel = 4'hf;
	logic [31:0]      rnd = 32'heff1_1071;
	logic [DAT_W-1:0] q;
	int               mismatches = 0;
	int               n_compared = 0;

	always #2.5 clk_i = ~clk_i;

	sps_regs sps_regs_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .tx_level_i(tx_l), .rx_level_i(rx_l),
		.shifter_busy_i(busy), .rx_timeout_i(to_p), .rx_word_in_i(word_p),
		.prescale_tick_o(prescale_tick_o), .irq_o(irq_o),
		.evt_irq_o(evt_irq_o));

	sps_port_model sps_port_model_i (.clk_i(clk_i), .tx_o(tx_l),
		.rx_o(rx_l), .busy_o(busy), .to_o(to_p), .word_o(word_p));

	////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [DAT_W-1:0] s, e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// One classic cycle; request held until ack is sampled
	task automatic wb(input logic we, input logic [ADR_W-1:0] a,
		input logic [DAT_W-1:0] d);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= sel;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
		if (n >= 50) begin
			mismatches++;
			summarize;
		end
	endtask : wb

	task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [ADR_W-1:0] a, input logic [31:0] e,
		input string nm);
		wb(1'b0, a, '0);
		chk(nm, q, e);
	endtask : rdc

	// Cycles between two prescale ticks
	task automatic period(input int e);
		int c;
		for (int k = 0; k < 2; k++) begin
			c = 0;
			do begin
				@(posedge clk_i);
				c++;
			end while (prescale_tick_o !== 1'b1 && c < 600);
		end
		chk("tick period", c, e);
		if (c >= 600)
			summarize;
	endtask : period

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [31:0] exp_st(input logic [3:0] a, b,
		input logic y);
		return {27'h0, y | (a != 4'h0), b == QUEUE_DEPTH, b != 4'h0,
			a != QUEUE_DEPTH, a == 4'h0};
	endfunction : exp_st

	function automatic logic [31:0] exp_raw(input logic [3:0] a, b,
		input logic o, v);
		return {28'h0, a <= QUEUE_HALF, b >= QUEUE_HALF, o, v};
	endfunction : exp_raw

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdc(OFF_STATUS, 32'h0000_0003, "status");
		rdc(OFF_PRESCL, '0, "prescale");
		rdc(OFF_MASK, '0, "mask");
		rdc(OFF_RAW, 32'h0000_0008, "raw");
		rdc(OFF_MASKED, '0, "masked");
		rdc(OFF_IDENT4, {24'h0, IDENT4_VAL}, "ident4");
		rdc(OFF_IDENT5, {24'h0, IDENT5_VAL}, "ident5");
		wr(OFF_IDENT4, 32'hffff_ffff);
		rdc(OFF_IDENT4, {24'h0, IDENT4_VAL}, "ident4 wr");
		rdc(12'h100, '0, "unmapped");
		ovr = 1'b0;
		// Random levels with a full receive queue every fifth pass
		for (int i = 0; i < 40; i++) begin
			rnd = lfsr(rnd);
			t = 4'(rnd[7:0] % 9);
			r = (i % 5 == 0) ? 4'h8 : 4'(rnd[15:8] % 9);
			w = rnd[20] | (i == 0);
			sps_port_model_i.set_lv(t, r, rnd[16]);
			@(posedge clk_i);
			sps_port_model_i.pulse(1'b0, w);
			ovr = ovr | (w & (r == 4'h8));
			repeat (2) @(posedge clk_i);
			rdc(OFF_STATUS, exp_st(t, r, rnd[16]), "status");
			rdc(OFF_RAW, exp_raw(t, r, 1'b0, ovr), "raw");
		end
		// Even divisors in range; odd value reads back even
		wr(OFF_PRESCL, 32'h0000_0003);
		rdc(OFF_PRESCL, 32'h0000_0002, "prescale odd");
		period(2);
		rnd = lfsr(rnd);
		wr(OFF_PRESCL, {24'h0, rnd[7:1] | 7'h01, 1'b0});
		period(int'({rnd[7:1] | 7'h01, 1'b0}));
		// Sticky timeout and overrun, clear by ones only
		sps_port_model_i.set_lv(4'h5, 4'h0, 1'b0);
		wr(OFF_CLEAR, 32'h0000_0003);
		rdc(OFF_RAW, '0, "raw cleared");
		sps_port_model_i.pulse(1'b1, 1'b0);
		wr(OFF_MASK, 32'h0000_0002);
		rdc(OFF_RAW, 32'h0000_0002, "raw timeout");
		rdc(OFF_MASKED, 32'h0000_0002, "masked");
		chk("irq set", irq_o, 1'b1);
		wr(OFF_CLEAR, 32'h0000_0000);
		wr(OFF_RAW, 32'h0000_000f);
		wr(OFF_MASKED, 32'h0000_0000);
		rdc(OFF_RAW, 32'h0000_0002, "raw kept");
		wr(OFF_CLEAR, 32'h0000_0002);
		rdc(OFF_RAW, '0, "raw timeout clr");
		chk("irq clear", irq_o, 1'b0);
		// Level sources under random masks; clear leaves them alone
		sps_port_model_i.set_lv(4'h0, 4'h8, 1'b0);
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			mk = rnd[3:0];
			wr(OFF_MASK, rnd);
			wr(OFF_CLEAR, 32'h0000_000f);
			rdc(OFF_MASK, {28'h0, mk}, "mask");
			rdc(OFF_RAW, 32'h0000_000c, "raw level");
			rdc(OFF_MASKED, {28'h0, mk & 4'hc}, "masked");
			chk("irq level", irq_o, |(mk & 4'hc));
		end
		// A write without the low byte lane is dropped
		sel = 4'he;
		wr(OFF_MASK, 32'h0000_0000);
		sel = 4'hf;
		rdc(OFF_MASK, {28'h0, mk}, "mask sel");
		// Event register: read clears, mask gates the event interrupt
		wr(OFF_EVMASK, 32'h0000_0002);
		wb(1'b0, OFF_EVENT, '0);
		sps_port_model_i.pulse(1'b1, 1'b0);
		repeat (3) @(posedge clk_i);
		chk("evt irq", evt_irq_o, 1'b1);
		rdc(OFF_EVENT, 32'h0000_0002, "event");
		rdc(OFF_EVENT, '0, "event read clr");
		chk("evt irq clr", evt_irq_o, 1'b0);
		summarize;
	end

endmodule : serial_port_status_irq_bench
